// File: arsel_pkg.sv
// arsel_pkg: register map, field positions, reset values and timing for the converter control block
// assumes a 32-bit apb slave at 125 mhz; one register per aligned word
package arsel_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_RESULT_LOW   = 8'h00;
    localparam logic [7:0] ADDR_RESULT_HIGH  = 8'h04;
    localparam logic [7:0] ADDR_CONV_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_SRC_CLK_CFG  = 8'h0C;

    // conv_control fields
    localparam int CTL_START_BIT  = 7;
    localparam int CTL_BUSY_BIT   = 6;
    localparam int CTL_ENABLE_BIT = 5;
    localparam int CTL_ALIGN_BIT  = 4;
    localparam int CTL_CHAN_LSB   = 0;

    // source_clock_config fields
    localparam int CFG_SRC_LSB = 5;
    localparam int CFG_REF_LSB = 3;
    localparam int CFG_CLK_LSB = 0;

    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // conversion time
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_TIME_NS  = 112;
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // converted-signal selection
    typedef enum logic [2:0] {
        ARSEL_SRC_EXT   = 3'b000,
        ARSEL_SRC_BG    = 3'b001,
        ARSEL_SRC_AMP   = 3'b010,
        ARSEL_SRC_AMP_B = 3'b011,
        ARSEL_SRC_VSS   = 3'b100
    } arsel_src_t;

    typedef enum logic [1:0] {
        ARSEL_IDLE  = 2'b00,
        ARSEL_ARMED = 2'b01,
        ARSEL_CONV  = 2'b10
    } arsel_state_t;

endpackage

// File: arsel_top.sv
// arsel_top: converter control, input select and result registers behind apb
// assumes the analog front end delivers a 12-bit sample on sample_data when sampled
`timescale 1ns/1ps
`default_nettype none

module arsel_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // analog front end
    input  wire logic [11:0] sample_data,
    output logic             conv_active,
    output logic [12:0]      input_route_onehot,
    output logic [1:0]       reference_sel,
    output logic [2:0]       conv_clock_sel
);

    logic [7:0]  ctl_q;
    logic [7:0]  cfg_q;
    logic [11:0] result_q;
    logic        busy_q;
    logic [7:0]  cnt_q;
    logic [31:0] prdata_q;
    arsel_pkg::arsel_state_t state_q;

    logic        wr_en;
    logic        rd_en;
    logic        enabled;
    logic        start_bit;
    logic        align;
    logic [3:0]  chan;
    logic [2:0]  src;
    logic        done;
    logic [7:0]  busy_run_q;

    // route decode: bits 0..9 external pins, 10 bandgap, 11 amplifier, 12 negative supply
    function automatic logic [12:0] route_decode(input logic [2:0] s, input logic [3:0] c);
        logic [12:0] r;
        r = 13'h0000;
        case (arsel_pkg::arsel_src_t'(s))
            arsel_pkg::ARSEL_SRC_BG:    r[10] = 1'b1;
            arsel_pkg::ARSEL_SRC_AMP:   r[11] = 1'b1;
            arsel_pkg::ARSEL_SRC_AMP_B: r[11] = 1'b1; // both 01x codes map to amplifier output
            arsel_pkg::ARSEL_SRC_VSS:   r[12] = 1'b1;
            default:
            begin
                // channel seven and codes above nine stay unconnected (floating)
                if (c != 4'h7 && c <= 4'h9)
                    r[c] = 1'b1;
            end
        endcase
        return r;
    endfunction

    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && penable && !pwrite;
    assign enabled   = ctl_q[arsel_pkg::CTL_ENABLE_BIT];
    assign start_bit = ctl_q[arsel_pkg::CTL_START_BIT];
    assign align     = ctl_q[arsel_pkg::CTL_ALIGN_BIT];
    assign chan      = ctl_q[arsel_pkg::CTL_CHAN_LSB +: 4];
    assign src       = cfg_q[arsel_pkg::CFG_SRC_LSB +: 3];
    assign done      = (state_q == arsel_pkg::ARSEL_CONV) && (cnt_q == 8'h01);

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_q;

    assign conv_active        = busy_q;
    assign input_route_onehot = route_decode(src, chan);
    assign reference_sel      = cfg_q[arsel_pkg::CFG_REF_LSB +: 2];
    assign conv_clock_sel     = cfg_q[arsel_pkg::CFG_CLK_LSB +: 3];

    // control register; busy bit is hardware-owned
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ctl_q <= arsel_pkg::CTL_RESET;
        else if (clk_en && wr_en && paddr == arsel_pkg::ADDR_CONV_CONTROL)
            ctl_q <= pwdata[7:0] & 8'hBF;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            cfg_q <= arsel_pkg::CFG_RESET;
        else if (clk_en && wr_en && paddr == arsel_pkg::ADDR_SRC_CLK_CFG)
            cfg_q <= pwdata[7:0];
    end

    // start sequencer: arm on high, launch on fall
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= arsel_pkg::ARSEL_IDLE;
            cnt_q   <= 8'h00;
            busy_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_q)
                arsel_pkg::ARSEL_IDLE:
                begin
                    if (start_bit && enabled)
                        state_q <= arsel_pkg::ARSEL_ARMED;
                end
                arsel_pkg::ARSEL_ARMED:
                begin
                    if (!enabled)
                        state_q <= arsel_pkg::ARSEL_IDLE;
                    else if (!start_bit)
                    begin
                        state_q <= arsel_pkg::ARSEL_CONV;
                        cnt_q   <= 8'(arsel_pkg::CONV_CYCLES);
                        busy_q  <= 1'b1;
                    end
                end
                arsel_pkg::ARSEL_CONV:
                begin
                    // disabling aborts; result is then left untouched
                    if (!enabled || done)
                    begin
                        state_q <= arsel_pkg::ARSEL_IDLE;
                        busy_q  <= 1'b0;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                default:
                begin
                    state_q <= arsel_pkg::ARSEL_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // result capture only while enabled
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            result_q <= arsel_pkg::RESULT_RESET;
        else if (clk_en && done && enabled)
            result_q <= sample_data;
    end

    // read mux
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            prdata_q <= 32'h0000_0000;
        else if (clk_en && psel && !penable && !pwrite)
        begin
            case (paddr)
                arsel_pkg::ADDR_RESULT_LOW:
                    prdata_q <= align ? {24'h00_0000, result_q[7:0]}
                                      : {24'h00_0000, result_q[3:0], 4'h0};
                arsel_pkg::ADDR_RESULT_HIGH:
                    prdata_q <= align ? {24'h00_0000, 4'h0, result_q[11:8]}
                                      : {24'h00_0000, result_q[11:4]};
                arsel_pkg::ADDR_CONV_CONTROL:
                    prdata_q <= {24'h00_0000, ctl_q[7], busy_q, ctl_q[5:0]};
                arsel_pkg::ADDR_SRC_CLK_CFG:
                    prdata_q <= {24'h00_0000, cfg_q};
                default:
                    prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // assertions
    property busy_follows_fall_p;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && state_q == arsel_pkg::ARSEL_ARMED && enabled && !start_bit) |=> busy_q;
    endproperty
    busy_start_a: assert property (busy_follows_fall_p) else $error("busy not set after start fell");

    result_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !enabled |=> $stable(result_q)) else $error("result changed while disabled");

    result_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && done && enabled) |=> (result_q == $past(sample_data) && !busy_q))
        else $error("result not captured at end of conversion");

    route_ch7_a: assert property (@(posedge mclk) disable iff (!rstn)
        (src == 3'b000 && chan == 4'h7) |-> input_route_onehot == 13'h0000)
        else $error("channel seven routed");

    route_bg_a: assert property (@(posedge mclk) disable iff (!rstn)
        (src == 3'b001) |-> input_route_onehot == 13'h0400) else $error("bandgap not routed");

    route_supply_a: assert property (@(posedge mclk) disable iff (!rstn)
        (src == 3'b100) |-> input_route_onehot == 13'h1000) else $error("supply not routed");

    ro_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
        !ctl_q[arsel_pkg::CTL_BUSY_BIT]) else $error("busy bit stored by software");

    read_pad_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && psel && !penable && !pwrite && paddr == arsel_pkg::ADDR_RESULT_HIGH && align)
        |=> prdata[7:4] == 4'h0) else $error("unused high bits not zero");

    busy_len_a: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(busy_q) && clk_en |-> busy_q [*8]) else $error("conversion too short");

    // helper: cycles spent busy, too many for a repetition
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            busy_run_q <= 8'h00;
        else if (clk_en)
            busy_run_q <= busy_q ? busy_run_q + 8'h01 : 8'h00;
    end

    // first half of the start handshake
    sequence start_high_s;
        clk_en && state_q == arsel_pkg::ARSEL_IDLE && start_bit && enabled;
    endsequence

    // start fell while armed and enabled
    sequence armed_fall_s;
        clk_en && state_q == arsel_pkg::ARSEL_ARMED && enabled && !start_bit;
    endsequence

    // counter loaded, busy shown
    sequence launched_s;
        busy_q && state_q == arsel_pkg::ARSEL_CONV && cnt_q == 8'(arsel_pkg::CONV_CYCLES);
    endsequence

    // last counted cycle of a conversion still enabled
    sequence finishing_s;
        clk_en && done && enabled;
    endsequence

    conv_arm_a: assert property (@(posedge mclk) disable iff (!rstn)
        start_high_s |=> state_q == arsel_pkg::ARSEL_ARMED)
        else $error("start high not armed");

    conv_launch_a: assert property (@(posedge mclk) disable iff (!rstn)
        armed_fall_s |=> launched_s)
        else $error("conversion not launched on start fall");

    conv_finish_a: assert property (@(posedge mclk) disable iff (!rstn)
        finishing_s |=> (!busy_q && state_q == arsel_pkg::ARSEL_IDLE))
        else $error("busy not cleared with result");

    busy_count_a: assert property (@(posedge mclk) disable iff (!rstn)
        finishing_s |-> busy_run_q == 8'(arsel_pkg::CONV_CYCLES - 1))
        else $error("conversion length wrong");

    idle_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == arsel_pkg::ARSEL_IDLE |-> !busy_q)
        else $error("busy while idle");

    // abort must not touch the held result
    abort_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && state_q == arsel_pkg::ARSEL_CONV && !enabled) |=> (!busy_q && $stable(result_q)))
        else $error("abort changed result or left busy");

    route_amp_a: assert property (@(posedge mclk) disable iff (!rstn)
        (src[2:1] == 2'b01) |-> input_route_onehot == 13'h0800)
        else $error("amplifier not routed");

    route_ext_a: assert property (@(posedge mclk) disable iff (!rstn)
        (src inside {3'b000, 3'b101, 3'b110, 3'b111} && chan <= 4'h6)
        |-> input_route_onehot == (13'h0001 << chan))
        else $error("low external channel not routed");

    route_high_a: assert property (@(posedge mclk) disable iff (!rstn)
        (src inside {3'b000, 3'b101, 3'b110, 3'b111} && chan inside {4'h8, 4'h9})
        |-> input_route_onehot == (13'h0001 << chan))
        else $error("high external channel not routed");

    // register stores; busy bit never stored
    ctl_store_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && wr_en && paddr == arsel_pkg::ADDR_CONV_CONTROL)
        |=> ctl_q == ($past(pwdata[7:0]) & 8'hbf))
        else $error("control write lost");

    cfg_store_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && wr_en && paddr == arsel_pkg::ADDR_SRC_CLK_CFG)
        |=> cfg_q == $past(pwdata[7:0]))
        else $error("config write lost");

    result_ro_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && wr_en && !done && (paddr == arsel_pkg::ADDR_RESULT_LOW || paddr == arsel_pkg::ADDR_RESULT_HIGH))
        |=> $stable(result_q))
        else $error("result written by software");

    // read views of the result pair, the busy flag and the upper bits
    read_right_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && psel && !penable && !pwrite && paddr == arsel_pkg::ADDR_RESULT_LOW && align)
        |=> prdata == {24'h00_0000, $past(result_q[7:0])})
        else $error("right aligned low byte wrong");

    read_left_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && psel && !penable && !pwrite && paddr == arsel_pkg::ADDR_RESULT_HIGH && !align)
        |=> prdata == {24'h00_0000, $past(result_q[11:4])})
        else $error("left aligned high byte wrong");

    read_low_pad_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && psel && !penable && !pwrite && paddr == arsel_pkg::ADDR_RESULT_LOW && !align)
        |=> prdata[3:0] == 4'h0)
        else $error("unused low bits not zero");

    read_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_en && psel && !penable && !pwrite && paddr == arsel_pkg::ADDR_CONV_CONTROL)
        |=> prdata[6] == $past(busy_q))
        else $error("busy flag not readable");

    upper_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        prdata[31:8] == 24'h00_0000)
        else $error("byte registers show upper bits");

endmodule

`default_nettype wire

// File: arsel_afe_model.sv
// arsel_afe_model: analog front end seen by the converter
// assumes route is one-hot from the block; level set by the bench
`timescale 1ns/1ps
`default_nettype none

module arsel_afe_model (
    // select from the block, level from the bench
    input  wire logic [12:0] route,
    input  wire logic [11:0] level,
    // sample back
    output logic      [11:0] sample
);
    always_comb
    begin
        // nothing routed: floating input, never the last value
        sample = ~level;
        for (int i = 0; i < 13; i++)
            if (route[i])
                sample = level + 12'(i);
    end
endmodule

`default_nettype wire

// File: test_adc_result_and_input_select.sv
// test_adc_result_and_input_select: self-checking bench for arsel_top
// assumes zero-wait apb slave and the front end model beside it
`timescale 1ns/1ps
`default_nettype none

module test_adc_result_and_input_select;
    logic        mclk = 0, rstn = 0, clk_en = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready, pslverr, conv_active;
    logic [31:0] prdata, seed = 32'hc30b_96c7;
    logic [11:0] sample_data, level = 12'h000, last_e = 12'h000;
    logic [12:0] input_route_onehot;
    logic [1:0]  reference_sel;
    logic [2:0]  conv_clock_sel;
    int          mismatches = 0, comparisons = 0, cyc = 0;

    arsel_top dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .sample_data(sample_data), .conv_active(conv_active),
        .input_route_onehot(input_route_onehot), .reference_sel(reference_sel),
        .conv_clock_sel(conv_clock_sel));
    arsel_afe_model afe (.route(input_route_onehot), .level(level), .sample(sample_data));

    always #4 mclk = ~mclk;

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard well above the roughly 1400 cycles needed
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 50000)
        begin
            mismatches++;
            complete_run;
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
        // idle edge: release never meets the next request, outputs settle
        @(posedge mclk);
    endtask

    function automatic logic [12:0] exp_route(input int s, input int c);
        if (s == 1) return 13'h0400;
        if (s == 2 || s == 3) return 13'h0800;
        if (s == 4) return 13'h1000;
        return (c <= 9 && c != 7) ? 13'(1) << c : 13'h0000;
    endfunction

    function automatic logic [63:0] exp_res(input logic f, input logic [11:0] e);
        return f ? {28'h0, e[11:8], 24'h0, e[7:0]} : {24'h0, e[11:4], 24'h0, e[3:0], 4'h0};
    endfunction

    // start high then low with enable set; level changes before start only
    task automatic conv(input int s, input logic [11:0] lv);
        logic [31:0] r, h;
        logic f;
        int n;
        f = s[0];
        last_e = lv + 12'(s == 0 ? 3 : s == 1 ? 10 : s < 4 ? 11 : 12);
        level <= lv;
        apb(1, arsel_pkg::ADDR_SRC_CLK_CFG, 32'(s) << 5, r);
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_00a3 | 32'(f) << 4, r);
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_0023 | 32'(f) << 4, r);
        @(posedge mclk);
        chk(64'(conv_active), 64'h1);
        apb(0, arsel_pkg::ADDR_CONV_CONTROL, 32'h0, r);
        chk(64'(r[6]), 64'h1);
        n = 0;
        while (conv_active !== 1'b0)
        begin
            @(posedge mclk);
            n++;
        end
        chk(64'(n), 64'(arsel_pkg::CONV_CYCLES - 3));
        apb(0, arsel_pkg::ADDR_RESULT_LOW, 32'h0, r);
        apb(0, arsel_pkg::ADDR_RESULT_HIGH, 32'h0, h);
        chk({h, r}, exp_res(f, last_e));
    endtask

    initial
    begin
        logic [31:0] r, h;
        repeat (16) @(posedge mclk);
        rstn <= 1;
        @(posedge mclk);
        for (int a = 0; a <= 16; a += 4)
        begin
            apb(0, 8'(a), 32'h0, r);
            chk(64'(r), 64'h0);
        end
        for (int s = 0; s < 8; s++)
            for (int c = 0; c < 16; c++)
            begin
                seed = lfsr(seed);
                apb(1, arsel_pkg::ADDR_SRC_CLK_CFG, {24'h0, 3'(s), seed[4:0]}, r);
                apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'(c), r);
                chk(64'(input_route_onehot), 64'(exp_route(s, c)));
                chk(64'({reference_sel, conv_clock_sel}), 64'(seed[4:0]));
                apb(0, arsel_pkg::ADDR_CONV_CONTROL, 32'h0, r);
                chk(64'(r), 64'(c));
            end
        for (int s = 0; s < 5; s++)
        begin
            seed = lfsr(seed);
            conv(s, seed[11:0]);
        end
        // abort mid conversion, then disabled: start ignored, result kept, result writes ignored
        level <= ~level;
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_00b0, r);
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_0030, r);
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_0010, r);
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_0090, r);
        apb(1, arsel_pkg::ADDR_CONV_CONTROL, 32'h0000_0010, r);
        apb(1, arsel_pkg::ADDR_RESULT_LOW, 32'h0000_00ff, r);
        repeat (20) @(posedge mclk);
        chk(64'(conv_active), 64'h0);
        apb(0, arsel_pkg::ADDR_RESULT_LOW, 32'h0, r);
        apb(0, arsel_pkg::ADDR_RESULT_HIGH, 32'h0, h);
        chk({h, r}, exp_res(1'b1, last_e));
        complete_run;
    end
endmodule

`default_nettype wire
